/* inc/udqo_regs.vh */
// constants for the queue head overlay engine: descriptor layout and
// field positions. assumes byte-addressed, word-aligned system memory.
`ifndef UDQO_REGS_VH
`define UDQO_REGS_VH

// ----------------------------------------------------------------------
// descriptor word offsets (bytes)
// ----------------------------------------------------------------------
`define UDQO_OFF_NEXT      8'h00
`define UDQO_OFF_TOKEN     8'h04
`define UDQO_OFF_PAGE0     8'h08
`define UDQO_OFF_PAGE4     8'h18

// ----------------------------------------------------------------------
// overlay geometry and word indices
// ----------------------------------------------------------------------
`define UDQO_OVL_WORDS     7
`define UDQO_IDX_NEXT      3'h0
`define UDQO_IDX_TOKEN     3'h1
`define UDQO_IDX_PAGE0     3'h2
`define UDQO_IDX_PAGE1     3'h3
`define UDQO_IDX_LAST      3'h6

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define UDQO_TERM_BIT      0
`define UDQO_PTR_HI        31
`define UDQO_PTR_LO        5
`define UDQO_TB_HI         30
`define UDQO_TB_LO         16
`define UDQO_IOC_BIT       15
`define UDQO_ACTIVE_BIT    7
`define UDQO_ERR_HI        6
`define UDQO_ERR_LO        0
`define UDQO_OFS_HI        11
`define UDQO_OFS_LO        0
`define UDQO_FRM_HI        10
`define UDQO_FRM_LO        0

// ----------------------------------------------------------------------
// reset values and setup geometry
// ----------------------------------------------------------------------
`define UDQO_PTR_RESET     32'h0000_0000
`define UDQO_SETUP_BYTES   4'h8

`endif

/* logic/udqo_engine.v */
// queue head overlay engine for one endpoint: fetches descriptors into
// the overlay, tracks the transfer, writes results back, walks the queue.
// assumes a word memory port with req/ack handshake and a packet engine
// that reports each finished transaction with a one-cycle pulse.
`timescale 1ns/10ps

module udqo_engine (
  input  wire        CLK,
  input  wire        RESETN,
  input  wire        PRIME,
  input  wire [31:0] PRIME_PTR,
  input  wire        TXN_DONE,
  input  wire        TXN_OK,
  input  wire [14:0] TXN_BYTES,
  input  wire        TXN_SHORT,
  input  wire [6:0]  TXN_ERR,
  input  wire [10:0] FRAME_NUM,
  input  wire        SETUP_VLD,
  input  wire [7:0]  SETUP_BYTE,
  input  wire        SETUP_QH_RX,
  input  wire        MEM_ACK,
  input  wire [31:0] MEM_RDATA,
  output reg         MEM_REQ,
  output reg         MEM_WE,
  output reg  [31:0] MEM_ADDR,
  output reg  [31:0] MEM_WDATA,
  output reg  [31:0] CUR_DTD_PTR,
  output reg         XFER_ACTIVE,
  output reg  [31:0] BUF_ADDR,
  output reg  [14:0] BYTES_LEFT,
  output reg         QUEUE_IDLE,
  output reg         USB_EVENT_INT,
  output wire [31:0] SETUP_WORD0,
  output wire [31:0] SETUP_WORD1,
  output wire        SETUP_RDY
);
`include "udqo_regs.vh"

  // ----------------------------------------------------------------------
  // states, one-hot
  // ----------------------------------------------------------------------
  localparam [4:0] S_IDLE  = 5'h01;  // waiting for priming
  localparam [4:0] S_FETCH = 5'h02;  // copying descriptor into overlay
  localparam [4:0] S_EXEC  = 5'h04;  // transfer running on endpoint
  localparam [4:0] S_WBACK = 5'h08;  // results back to memory
  localparam [4:0] S_ADV   = 5'h10;  // step to next descriptor

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  reg  [31:0] ovl_r [0:`UDQO_OVL_WORDS-1];  // overlay working copy
  reg  [4:0]  state_r;                      // current state
  reg  [2:0]  idx_r;                        // word index for fetch/wback
  reg  [31:0] cur_r;                        // current descriptor pointer
  integer     i;                            // overlay reset loop

  // ----------------------------------------------------------------------
  // transaction arithmetic
  // ----------------------------------------------------------------------
  wire [14:0] tb_now  = ovl_r[`UDQO_IDX_TOKEN][`UDQO_TB_HI:`UDQO_TB_LO];
  wire [11:0] ofs_now = ovl_r[`UDQO_IDX_PAGE0][`UDQO_OFS_HI:`UDQO_OFS_LO];
  wire        ovl_act = ovl_r[`UDQO_IDX_TOKEN][`UDQO_ACTIVE_BIT];
  // clamp so a misbehaving engine cannot wrap the count below zero
  wire        over    = (TXN_BYTES > tb_now);
  wire [14:0] tb_left = over ? 15'h0000 : (tb_now - TXN_BYTES);
  wire [11:0] ofs_nxt = ofs_now + TXN_BYTES[11:0];
  wire        fin     = (~TXN_OK) | TXN_SHORT | (tb_left == 15'h0000);
  wire [31:0] wb_addr = cur_r + {27'h0, idx_r, 2'b00};
  wire [31:0] nxt_ptr = {ovl_r[`UDQO_IDX_NEXT][`UDQO_PTR_HI:`UDQO_PTR_LO],
                         5'b00000};
  wire        nxt_trm = ovl_r[`UDQO_IDX_NEXT][`UDQO_TERM_BIT];

  // ----------------------------------------------------------------------
  // main sequencer
  // ----------------------------------------------------------------------
  // one process keeps the overlay and its control in lock step
  always @(posedge CLK) begin
    if (!RESETN) begin
      state_r       <= S_IDLE;
      idx_r         <= 3'h0;
      cur_r         <= `UDQO_PTR_RESET;
      MEM_REQ       <= 1'b0;
      MEM_WE        <= 1'b0;
      MEM_ADDR      <= 32'h0000_0000;
      MEM_WDATA     <= 32'h0000_0000;
      USB_EVENT_INT <= 1'b0;
      for (i = 0; i < `UDQO_OVL_WORDS; i = i + 1)
        ovl_r[i] <= 32'h0000_0000;
    end else begin
      USB_EVENT_INT <= 1'b0;            // pulse by default
      case (state_r)
        // idle: priming is the only way in; bits 4..0 forced clear
        S_IDLE: begin
          if (PRIME) begin
            cur_r   <= {PRIME_PTR[`UDQO_PTR_HI:`UDQO_PTR_LO],
                        5'b00000};
            idx_r   <= 3'h0;
            state_r <= S_FETCH;
          end
        end
        // fetch: one read per word, next link at 0x00 upward
        S_FETCH: begin
          if (!MEM_REQ) begin
            MEM_REQ  <= 1'b1;
            MEM_WE   <= 1'b0;
            MEM_ADDR <= wb_addr;
          end else if (MEM_ACK) begin
            MEM_REQ      <= 1'b0;
            ovl_r[idx_r] <= MEM_RDATA;
            if (idx_r == `UDQO_IDX_LAST) begin
              idx_r   <= 3'h0;
              state_r <= S_EXEC;
            end else begin
              idx_r <= idx_r + 3'h1;
            end
          end
        end
        // execute: only an active overlay lets the endpoint run
        S_EXEC: begin
          if (!ovl_act) begin
            state_r <= S_IDLE;
          end else if (TXN_DONE) begin
            if (TXN_OK) begin
              ovl_r[`UDQO_IDX_TOKEN][`UDQO_TB_HI:`UDQO_TB_LO] <=
                tb_left;
              ovl_r[`UDQO_IDX_PAGE0][`UDQO_OFS_HI:`UDQO_OFS_LO] <=
                ofs_nxt;
            end else begin
              // error bits accumulate in the status byte
              ovl_r[`UDQO_IDX_TOKEN][`UDQO_ERR_HI:`UDQO_ERR_LO] <=
                ovl_r[`UDQO_IDX_TOKEN][`UDQO_ERR_HI:`UDQO_ERR_LO]
                | TXN_ERR;
            end
            if (fin) begin
              ovl_r[`UDQO_IDX_TOKEN][`UDQO_ACTIVE_BIT] <= 1'b0;
              ovl_r[`UDQO_IDX_PAGE1][`UDQO_FRM_HI:`UDQO_FRM_LO] <=
                FRAME_NUM;
              idx_r   <= `UDQO_IDX_TOKEN;
              state_r <= S_WBACK;
            end
          end
        end
        // write back: only words 0x04..0x0c carry device fields
        S_WBACK: begin
          if (!MEM_REQ) begin
            MEM_REQ   <= 1'b1;
            MEM_WE    <= 1'b1;
            MEM_ADDR  <= wb_addr;
            MEM_WDATA <= ovl_r[idx_r];
          end else if (MEM_ACK) begin
            MEM_REQ <= 1'b0;
            MEM_WE  <= 1'b0;
            if (idx_r == `UDQO_IDX_PAGE1)
              state_r <= S_ADV;
            else
              idx_r <= idx_r + 3'h1;
          end
        end
        // advance: event first, then follow the link unless terminated
        S_ADV: begin
          USB_EVENT_INT <= ovl_r[`UDQO_IDX_TOKEN][`UDQO_IOC_BIT];
          idx_r <= 3'h0;
          if (nxt_trm) begin
            state_r <= S_IDLE;
          end else begin
            cur_r   <= nxt_ptr;
            state_r <= S_FETCH;
          end
        end
        default: begin
          state_r <= S_IDLE;
          MEM_REQ <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // registered views for the packet engine and software
  // ----------------------------------------------------------------------
  // outputs lag the overlay by one cycle; the packet engine must not
  // start a transaction before XFER_ACTIVE rises
  always @(posedge CLK) begin
    if (!RESETN) begin
      CUR_DTD_PTR <= `UDQO_PTR_RESET;
      XFER_ACTIVE <= 1'b0;
      BUF_ADDR    <= 32'h0000_0000;
      BYTES_LEFT  <= 15'h0000;
      QUEUE_IDLE  <= 1'b1;
    end else begin
      CUR_DTD_PTR <= cur_r;
      XFER_ACTIVE <= (state_r == S_EXEC) & ovl_act & ~TXN_DONE;
      // page 0 base plus running offset; page crossing is left to
      // the packet engine, which sees the other pages via memory
      BUF_ADDR    <= {ovl_r[`UDQO_IDX_PAGE0][31:12], ofs_now};
      BYTES_LEFT  <= tb_now;
      QUEUE_IDLE  <= (state_r == S_IDLE);
    end
  end

  // ----------------------------------------------------------------------
  // setup capture
  // ----------------------------------------------------------------------
  udqo_setup_buf u_setup (
    .clk      (CLK),
    .resetn   (RESETN),
    .byte_vld (SETUP_VLD),
    .byte_in  (SETUP_BYTE),
    .qh_rx    (SETUP_QH_RX),
    .word0    (SETUP_WORD0),
    .word1    (SETUP_WORD1),
    .rdy      (SETUP_RDY)
  );

endmodule // udqo_engine

/* logic/udqo_setup_buf.v */
// setup buffer: packs the eight bytes after a setup token into two words.
// assumes bytes arrive in order, one per valid cycle, byte 0 first.
`timescale 1ns/10ps

module udqo_setup_buf (
  input  wire        clk,
  input  wire        resetn,
  input  wire        byte_vld,   // one byte per pulse
  input  wire [7:0]  byte_in,    // setup data byte
  input  wire        qh_rx,      // byte belongs to the receive queue head
  output reg  [31:0] word0,      // bytes 3..0
  output reg  [31:0] word1,      // bytes 7..4
  output reg         rdy         // both words hold a whole packet
);
`include "udqo_regs.vh"

  // ----------------------------------------------------------------------
  // byte capture
  // ----------------------------------------------------------------------
  reg [3:0] cnt_r;               // bytes taken of the current packet
  wire      take = byte_vld & qh_rx;

  // capture process; a new packet restarts the count after eight bytes
  always @(posedge clk) begin
    if (!resetn) begin
      cnt_r <= 4'h0;
      word0 <= 32'h0000_0000;
      word1 <= 32'h0000_0000;
      rdy   <= 1'b0;
    end else if (take) begin
      // first byte of a packet clears the ready flag
      if (cnt_r == 4'h0)
        rdy <= 1'b0;
      // low two bits of the count pick the lane, byte 0 in bits 7..0
      if (cnt_r[2] == 1'b0) begin
        word0[cnt_r[1:0]*8 +: 8] <= byte_in;
      end else begin
        word1[cnt_r[1:0]*8 +: 8] <= byte_in;
      end
      if (cnt_r == `UDQO_SETUP_BYTES - 4'h1) begin
        cnt_r <= 4'h0;
        rdy   <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

endmodule // udqo_setup_buf

/* verif/udqo_mem_model.sv */
// system memory holding descriptors, answering after lat cycles.
// assumes word requests held until ack; drives on the falling edge.
`timescale 1ns/10ps

module udqo_mem_model (
  input  wire         clk,
  input  wire         mem_req,
  input  wire         mem_we,
  input  wire  [31:0] mem_addr,
  input  wire  [31:0] mem_wdata,
  input  wire  [3:0]  lat,
  output logic        mem_ack,
  output logic [31:0] mem_rdata
);
  // only the engine writes here while a descriptor is live
  logic [31:0] mem [0:63];
  logic [3:0]  wait_r;     // cycles waited on this request
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0;
    wait_r = 4'h0;
    // descriptor image: A chains to B, B to D, D ends, C never active
    for (int i = 0; i < 64; i++) mem[i] = 32'h0;
    mem[16] = 32'h0000_0080; // A next: B
    mem[17] = 32'h0020_8080; // 0x20 bytes, ioc, active
    mem[18] = 32'h1234_5010;
    mem[19] = 32'habcd_e000;
    mem[32] = 32'h0000_00a0; // B next: D
    mem[33] = 32'h0008_0080;
    mem[40] = 32'h0000_0001; // D ends the queue
    mem[41] = 32'h000c_0080;
    mem[49] = 32'h0004_0000; // C never active
  end
  // idle data toggles so a stale read never looks right
  always @(negedge clk) begin
    if (mem_ack || !mem_req) begin
      mem_ack <= 1'b0;
      wait_r <= 4'h0;
      mem_rdata <= ~mem_rdata;
    end else if (wait_r < lat) begin
      wait_r <= wait_r + 4'h1;
      mem_rdata <= ~mem_rdata;
    end else begin
      mem_ack <= 1'b1;
      if (mem_we) mem[mem_addr[7:2]] <= mem_wdata;
      else mem_rdata <= mem[mem_addr[7:2]];
    end
  end
endmodule // udqo_mem_model

/* verif/udqo_monitor.sv */
// checker for the overlay engine: memory port, pointer, setup words.
// assumes one clock and the engine's synchronous active-low reset.
`timescale 1ns/10ps

module udqo_monitor (
  input wire        CLK,
  input wire        RESETN,
  input wire        TXN_DONE,
  input wire        TXN_OK,
  input wire        SETUP_VLD,
  input wire        SETUP_QH_RX,
  input wire        MEM_ACK,
  input wire        MEM_REQ,
  input wire        MEM_WE,
  input wire [31:0] MEM_ADDR,
  input wire [31:0] MEM_WDATA,
  input wire [31:0] CUR_DTD_PTR,
  input wire        XFER_ACTIVE,
  input wire [14:0] BYTES_LEFT,
  input wire        USB_EVENT_INT,
  input wire [31:0] SETUP_WORD0,
  input wire [31:0] SETUP_WORD1
);
  // ------------------------------------------------------------
  // properties, all on the one clock
  // ------------------------------------------------------------
  default clocking mon_cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  ptr_low_zero_a: assert property (CUR_DTD_PTR[4:0] == 5'h00)
    else $error("pointer low bits not zero");
  req_hold_a: assert property (MEM_REQ && !MEM_ACK |=> MEM_REQ
    && $stable(MEM_ADDR) && $stable(MEM_WE) && $stable(MEM_WDATA))
    else $error("memory request changed before ack");
  req_gap_a: assert property (MEM_REQ && MEM_ACK |=> !MEM_REQ)
    else $error("request not dropped after ack");
  // write back may only touch count, offset and frame words
  wb_fields_a: assert property (MEM_REQ && MEM_WE |->
    MEM_ADDR[31:5] == CUR_DTD_PTR[31:5] && (MEM_ADDR[4:0] == 5'h04
    || MEM_ADDR[4:0] == 5'h08 || MEM_ADDR[4:0] == 5'h0c))
    else $error("write outside updatable fields");
  exec_quiet_a: assert property (XFER_ACTIVE |-> !MEM_REQ)
    else $error("memory access while executing");
  int_pulse_a: assert property (USB_EVENT_INT |=> !USB_EVENT_INT)
    else $error("event interrupt longer than one cycle");
  done_drop_a: assert property (TXN_DONE && XFER_ACTIVE |=>
    !XFER_ACTIVE) else $error("active held after transaction");
  tx_setup_a: assert property (SETUP_VLD && !SETUP_QH_RX |=>
    $stable(SETUP_WORD0) && $stable(SETUP_WORD1))
    else $error("setup stored from transmit queue head");
  fail_count_a: assert property (TXN_DONE && !TXN_OK |->
    ##2 $stable(BYTES_LEFT)) else $error("count moved on failure");
endmodule // udqo_monitor

bind udqo_engine udqo_monitor udqo_monitor_i (.CLK(CLK),
  .RESETN(RESETN), .TXN_DONE(TXN_DONE), .TXN_OK(TXN_OK),
  .SETUP_VLD(SETUP_VLD), .SETUP_QH_RX(SETUP_QH_RX), .MEM_ACK(MEM_ACK),
  .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
  .MEM_WDATA(MEM_WDATA), .CUR_DTD_PTR(CUR_DTD_PTR),
  .XFER_ACTIVE(XFER_ACTIVE), .BYTES_LEFT(BYTES_LEFT),
  .USB_EVENT_INT(USB_EVENT_INT), .SETUP_WORD0(SETUP_WORD0),
  .SETUP_WORD1(SETUP_WORD1));

/* verif/udqo_tb.sv */
// testbench: setup capture, a three-descriptor chain, an inactive one.
// assumes the engine and the memory model; inputs move on negedge.
`timescale 1ns/10ps

module testbench;
  logic        CLK, RESETN, PRIME, TXN_DONE, TXN_OK, TXN_SHORT;
  logic        SETUP_VLD, SETUP_QH_RX, MEM_ACK, MEM_REQ, MEM_WE;
  logic        XFER_ACTIVE, QUEUE_IDLE, USB_EVENT_INT, SETUP_RDY;
  logic [31:0] PRIME_PTR, MEM_RDATA, MEM_ADDR, MEM_WDATA, CUR_DTD_PTR;
  logic [31:0] BUF_ADDR, SETUP_WORD0, SETUP_WORD1;
  logic [14:0] TXN_BYTES, BYTES_LEFT;
  logic [7:0]  SETUP_BYTE;
  logic [6:0]  TXN_ERR;
  logic [3:0]  lat;
  logic [10:0] FRAME_NUM;
  int          failures = 0, compares = 0, ints = 0, acts = 0, acts0;
  udqo_engine udqo_engine_i (.CLK(CLK), .RESETN(RESETN), .PRIME(PRIME),
    .PRIME_PTR(PRIME_PTR), .TXN_DONE(TXN_DONE), .TXN_OK(TXN_OK),
    .TXN_BYTES(TXN_BYTES), .TXN_SHORT(TXN_SHORT), .TXN_ERR(TXN_ERR),
    .FRAME_NUM(FRAME_NUM), .SETUP_VLD(SETUP_VLD), .SETUP_BYTE(SETUP_BYTE),
    .SETUP_QH_RX(SETUP_QH_RX), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA),
    .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
    .MEM_WDATA(MEM_WDATA), .CUR_DTD_PTR(CUR_DTD_PTR),
    .XFER_ACTIVE(XFER_ACTIVE), .BUF_ADDR(BUF_ADDR),
    .BYTES_LEFT(BYTES_LEFT), .QUEUE_IDLE(QUEUE_IDLE),
    .USB_EVENT_INT(USB_EVENT_INT), .SETUP_WORD0(SETUP_WORD0),
    .SETUP_WORD1(SETUP_WORD1), .SETUP_RDY(SETUP_RDY));
  udqo_mem_model udqo_mem_model_i (.clk(CLK), .mem_req(MEM_REQ),
    .mem_we(MEM_WE), .mem_addr(MEM_ADDR), .mem_wdata(MEM_WDATA),
    .lat(lat), .mem_ack(MEM_ACK), .mem_rdata(MEM_RDATA));
  initial begin
    CLK = 1'b0;
    forever #25 CLK = ~CLK;
  end
  // tally interrupts and any sign of execution
  always @(posedge CLK) begin
    if (USB_EVENT_INT === 1'b1) ints++;
    if (XFER_ACTIVE === 1'b1) acts++;
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task chk(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask
  task end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // bounded wait for idle (1) or active (0)
  task wait_hi(input bit idle);
    int n;
    n = 0;
    while ((idle ? QUEUE_IDLE : XFER_ACTIVE) !== 1'b1) begin
      @(negedge CLK);
      n++;
      if (n > 300) begin
        chk("wait bound", 32'h1, 32'h0);
        end_sim;
      end
    end
  endtask
  task txn(input logic ok, sh, input logic [14:0] n);
    @(negedge CLK);
    {TXN_DONE, TXN_OK, TXN_SHORT, TXN_BYTES} = {1'b1, ok, sh, n};
    TXN_ERR = ok ? 7'h00 : 7'h05;
    @(negedge CLK);
    TXN_DONE = 1'b0;
    repeat (3) @(negedge CLK);
  endtask
  task sbyte(input logic rx, input logic [7:0] b);
    @(negedge CLK);
    {SETUP_VLD, SETUP_QH_RX, SETUP_BYTE} = {1'b1, rx, b};
    @(negedge CLK);
    SETUP_VLD = 1'b0;
  endtask
  task prime(input logic [31:0] p);
    @(negedge CLK);
    {PRIME, PRIME_PTR} = {1'b1, p};
    @(negedge CLK);
    PRIME = 1'b0;
    repeat (3) @(negedge CLK);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {RESETN, PRIME, TXN_DONE, TXN_OK, TXN_SHORT, SETUP_VLD} = 6'h0;
    {SETUP_QH_RX, SETUP_BYTE, TXN_BYTES, TXN_ERR, lat} = 35'h0;
    {PRIME_PTR, FRAME_NUM} = {32'h0, 11'h2a5};
    repeat (5) @(negedge CLK);
    chk("rst flags", 32'h1, {MEM_REQ, XFER_ACTIVE, SETUP_RDY,
        QUEUE_IDLE});
    chk("rst ptr", 32'h0, CUR_DTD_PTR);
    RESETN = 1'b1;
    for (int i = 0; i < 8; i++) begin
      sbyte(1'b1, 8'h10 + i[7:0]);
      if (i == 3) sbyte(1'b0, 8'hee);
    end
    @(negedge CLK);
    chk("setup0", 32'h1312_1110, SETUP_WORD0);
    chk("setup1", 32'h1716_1514, SETUP_WORD1);
    chk("setup rdy", 32'h1, {31'h0, SETUP_RDY});
    sbyte(1'b1, 8'h20);
    chk("rdy clear", 32'h0, {31'h0, SETUP_RDY});
    chk("setup0 b", 32'h1312_1120, SETUP_WORD0);
    $display("test setup done");
    prime(32'h0000_005f);
    wait_hi(1'b0);
    chk("cur A", 32'h40, CUR_DTD_PTR);
    chk("left A", 32'h20, {17'h0, BYTES_LEFT});
    chk("buf A", 32'h1234_5010, BUF_ADDR);
    txn(1'b1, 1'b0, 15'h10);
    chk("left A1", 32'h10, {17'h0, BYTES_LEFT});
    chk("buf A1", 32'h1234_5020, BUF_ADDR);
    lat = 4'h3;
    txn(1'b1, 1'b0, 15'h10);
    wait_hi(1'b0);
    chk("cur B", 32'h80, CUR_DTD_PTR);
    chk("wb tok", 32'h8000,
        udqo_mem_model_i.mem[17] & 32'h7fff_80ff);
    chk("wb ofs", 32'h1234_5030, udqo_mem_model_i.mem[18]);
    chk("wb frm", 32'habcd_e2a5, udqo_mem_model_i.mem[19]);
    chk("wb next", 32'h80, udqo_mem_model_i.mem[16]);
    chk("ioc int", 32'h1, ints);
    $display("test chain done");
    txn(1'b0, 1'b0, 15'h4);
    chk("left fail", 32'h8, {17'h0, BYTES_LEFT});
    wait_hi(1'b0);
    chk("cur D", 32'ha0, CUR_DTD_PTR);
    chk("wb err", 32'h0008_0005, udqo_mem_model_i.mem[33]);
    FRAME_NUM = 11'h155;
    txn(1'b1, 1'b1, 15'h4);
    chk("left short", 32'h8, {17'h0, BYTES_LEFT});
    wait_hi(1'b1);
    chk("cur term", 32'ha0, CUR_DTD_PTR);
    chk("wb short", 32'h0008_0000,
        udqo_mem_model_i.mem[41] & 32'h7fff_80ff);
    chk("wb frm D", 32'h0000_0155, udqo_mem_model_i.mem[43]);
    chk("no ioc", 32'h1, ints);
    $display("test terminate done");
    acts0 = acts;
    prime(32'h0000_00c0);
    wait_hi(1'b1);
    chk("inactive", 32'h0, acts - acts0);
    chk("c tok", 32'h0004_0000, udqo_mem_model_i.mem[49]);
    chk("cur C", 32'hc0, CUR_DTD_PTR);
    $display("test inactive done");
    end_sim;
  end
endmodule // testbench
